//--- core/isc_pkg.sv
// Constants shared by the interrupt and standby controller
package isc_pkg;
    // ==========================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam real SETTLE_MS = 52.4;
    localparam int unsigned SETTLE_CYC = int'(SETTLE_MS * 20_000.0);
    // ==========================================
    // Vector addresses per level
    localparam logic [7:0] VEC_L0 = 8'h04;
    localparam logic [7:0] VEC_L1 = 8'h08;
    localparam logic [7:0] VEC_L2 = 8'h10;
    localparam logic [7:0] VEC_L3 = 8'h18;
    localparam logic [7:0] VEC_L4 = 8'h20;
    localparam logic [7:0] VEC_L5 = 8'h28;
    localparam logic [7:0] VEC_L6 = 8'h60;
    localparam logic [7:0] VEC_RESET = 8'h00;
    // ==========================================
    // Source bit positions in the pending vector
    localparam int unsigned NSRC = 12;
    localparam int unsigned SRC_NMI = 0;
    localparam int unsigned SRC_T0 = 1;
    localparam int unsigned SRC_T1 = 2;
    localparam int unsigned SRC_RISE = 3;
    localparam int unsigned SRC_FALL = 4;
    localparam int unsigned SRC_E0 = 5;
    localparam int unsigned SRC_E1 = 6;
    localparam int unsigned SRC_EIN = 7;
    localparam int unsigned SRC_AD = 8;
    localparam int unsigned SRC_SR = 9;
    localparam int unsigned SRC_ST = 10;
    localparam int unsigned SRC_SW = 11;
    localparam logic [11:0] PEND_RST = 12'h000;
    localparam logic [11:0] MASKABLE = 12'h7FE;
    // ==========================================
    // Power states
    typedef enum logic [2:0] {
        ISC_RUN = 3'b000,
        ISC_HALT = 3'b001,
        ISC_STOPA = 3'b010,
        ISC_SETTLE_A = 3'b011,
        ISC_STOPB = 3'b100,
        ISC_SETTLE_B = 3'b101
    } isc_state_e;
endpackage

//--- core/isc_ctrl.sv
// Interrupt prioritiser and standby wake-up control
// What this block does
// - Twelve sources: three pins, nine internal
// - Seven levels, level 0 highest, 6 lowest
// - Level 1: both timer matches, vector 8
// - Level 3: event counter matches, vector 24
// - Level 4: event edge or ADC, vector 32
// - Level 5: serial rx or tx, vector 40
// - Halt stops execution, clock keeps running
// - Unmasked request or reset ends halt
// - Stop instruction stops oscillator; NMI ends it
// - Type A settling timed by timer one
// - Standby flag tells wake from power-up
// - Stop pin low stops oscillator; high releases
// - Fixed settle then execute from address 0
// - Rising input reads 0 until crossing
// - Falling input reads 1 until crossing
// - Logic-driven inputs act as plain digital
// - First maskable pin requests on rising edge
// - NMI requests on falling edge
module isc_ctrl #(
    parameter int unsigned SETTLE_CYCLES = isc_pkg::SETTLE_CYC
) (
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset, high
    input wire logic nmi_n_pin, // Nonmaskable input, active low
    input wire logic rising_edge_irq_pin, // Comparator output, rising
    input wire logic falling_edge_irq_pin, // Comparator output, falling
    input wire logic stop_n_pin, // Hardware stop, active low
    input wire logic timer0_match_req, // Timer 0 match pulse
    input wire logic timer1_match_req, // Timer 1 match pulse
    input wire logic evcnt_match0_req, // Event counter match 0
    input wire logic evcnt_match1_req, // Event counter match 1
    input wire logic evcnt_falling_edge_req, // Event counter edge
    input wire logic adc_done_req, // ADC done
    input wire logic serial_rx_req, // Serial receive
    input wire logic serial_tx_req, // Serial transmit
    input wire logic software_trap, // Trap instruction
    input wire logic halt_instruction, // Halt instruction pulse
    input wire logic stop_instruction, // Stop instruction pulse
    input wire logic timer1_settle_done, // Timer 1 settle expiry
    input wire logic [11:0] irq_mask, // Mask per source, 1 masks; bits 0 and 11 ignored
    input wire logic irq_ack, // Core takes the vector
    input wire logic [11:0] pend_clear, // Software clears flags
    input wire logic sb_clear, // Software clears standby flag
    output logic irq_req, // Vectored request to core
    output logic [7:0] irq_vector, // Vector of winner
    output logic [2:0] irq_level, // Level of winner
    output logic [11:0] pend_flags, // Per-source pending
    output logic cpu_run, // Core may execute
    output logic osc_enable, // Oscillator running
    output logic restart_zero, // Restart from address 0 pulse
    output logic standby_indicator, // Woke from standby
    output logic rising_pin_level, // Sensed level, rising input
    output logic falling_pin_level // Sensed level, falling input
);
    // ==========================================
    // Pin sampling and edges
    logic nmi_q;
    logic rise_q;
    logic fall_q;
    wire nmi_edge = nmi_q & ~nmi_n_pin;
    wire rise_edge = ~rise_q & rising_edge_irq_pin;
    wire fall_edge = fall_q & ~falling_edge_irq_pin;

    // Previous pin levels; comparator output is plain logic
    always_ff @(posedge core_clk) begin
        if (reset) begin
            nmi_q <= 1'b1;
            rise_q <= 1'b0;
            fall_q <= 1'b1;
        end else begin
            nmi_q <= nmi_n_pin;
            rise_q <= rising_edge_irq_pin;
            fall_q <= falling_edge_irq_pin;
        end
    end

    // ==========================================
    // Pending flags, one per source
    logic [11:0] pend;
    logic [11:0] raw;
    assign raw = {software_trap, serial_tx_req, serial_rx_req, adc_done_req,
        evcnt_falling_edge_req, evcnt_match1_req, evcnt_match0_req, fall_edge,
        rise_edge, timer1_match_req, timer0_match_req, nmi_edge};

    // ==========================================
    // Priority grouping and selection
    wire [11:0] live = pend & ~(irq_mask & isc_pkg::MASKABLE);
    wire lv0 = live[isc_pkg::SRC_NMI];
    wire lv1 = live[isc_pkg::SRC_T0] | live[isc_pkg::SRC_T1];
    wire lv2 = live[isc_pkg::SRC_RISE] | live[isc_pkg::SRC_FALL];
    wire lv3 = live[isc_pkg::SRC_E0] | live[isc_pkg::SRC_E1];
    wire lv4 = live[isc_pkg::SRC_EIN] | live[isc_pkg::SRC_AD];
    wire lv5 = live[isc_pkg::SRC_SR] | live[isc_pkg::SRC_ST];
    wire lv6 = live[isc_pkg::SRC_SW];
    wire any_live = |live;
    logic [2:0] win_lvl;
    logic [7:0] win_vec;
    logic [11:0] win_bits;

    // Fixed priority, level 0 first
    always_comb begin
        win_lvl = 3'd6;
        win_vec = isc_pkg::VEC_L6;
        win_bits = 12'h800;
        if (lv0) begin
            win_lvl = 3'd0;
            win_vec = isc_pkg::VEC_L0;
            win_bits = 12'h001;
        end else if (lv1) begin
            win_lvl = 3'd1;
            win_vec = isc_pkg::VEC_L1;
            win_bits = 12'h006;
        end else if (lv2) begin
            win_lvl = 3'd2;
            win_vec = isc_pkg::VEC_L2;
            win_bits = 12'h018;
        end else if (lv3) begin
            win_lvl = 3'd3;
            win_vec = isc_pkg::VEC_L3;
            win_bits = 12'h060;
        end else if (lv4) begin
            win_lvl = 3'd4;
            win_vec = isc_pkg::VEC_L4;
            win_bits = 12'h180;
        end else if (lv5) begin
            win_lvl = 3'd5;
            win_vec = isc_pkg::VEC_L5;
            win_bits = 12'h600;
        end
    end

    // Levels 0, 2 and 6 clear on acknowledge; levels 1, 3, 4 and 5 by software
    wire [11:0] single_mask = 12'h801 | 12'h018;
    wire [11:0] ack_clr = (irq_ack && irq_req) ? (win_bits & single_mask) : 12'h000;
    wire [11:0] next_pend = (pend & ~(pend_clear | ack_clr)) | raw;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend <= isc_pkg::PEND_RST;
        end else begin
            pend <= next_pend;
        end
    end

    // ==========================================
    // Standby state machine
    isc_pkg::isc_state_e state;
    isc_pkg::isc_state_e next_state;
    logic [20:0] settle_cnt;
    wire settle_end = (settle_cnt == 21'(SETTLE_CYCLES - 1));

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            isc_pkg::ISC_RUN: begin
                if (!stop_n_pin) begin
                    next_state = isc_pkg::ISC_STOPB;
                end else if (stop_instruction) begin
                    next_state = isc_pkg::ISC_STOPA;
                end else if (halt_instruction) begin
                    next_state = isc_pkg::ISC_HALT;
                end
            end
            isc_pkg::ISC_HALT: begin
                if (!stop_n_pin) begin
                    next_state = isc_pkg::ISC_STOPB;
                end else if (any_live) begin
                    next_state = isc_pkg::ISC_RUN;
                end
            end
            isc_pkg::ISC_STOPA: begin
                if (!stop_n_pin) begin
                    next_state = isc_pkg::ISC_STOPB;
                end else if (nmi_edge) begin
                    next_state = isc_pkg::ISC_SETTLE_A;
                end
            end
            isc_pkg::ISC_SETTLE_A: begin
                if (!stop_n_pin) begin
                    next_state = isc_pkg::ISC_STOPB;
                end else if (timer1_settle_done) begin
                    next_state = isc_pkg::ISC_RUN;
                end
            end
            isc_pkg::ISC_STOPB: begin
                if (stop_n_pin) begin
                    next_state = isc_pkg::ISC_SETTLE_B;
                end
            end
            isc_pkg::ISC_SETTLE_B: begin
                if (!stop_n_pin) begin
                    next_state = isc_pkg::ISC_STOPB;
                end else if (settle_end) begin
                    next_state = isc_pkg::ISC_RUN;
                end
            end
            default: next_state = isc_pkg::ISC_RUN;
        endcase
    end

    wire next_run = (next_state == isc_pkg::ISC_RUN);
    wire next_osc = (next_state != isc_pkg::ISC_STOPA) && (next_state != isc_pkg::ISC_STOPB);
    wire enter_stop = (next_state == isc_pkg::ISC_STOPA) || (next_state == isc_pkg::ISC_STOPB);
    wire b_done = (state == isc_pkg::ISC_SETTLE_B) && stop_n_pin && settle_end;
    wire next_sb = enter_stop | (standby_indicator & ~sb_clear);

    // State, settle counter, outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= isc_pkg::ISC_RUN;
            settle_cnt <= '0;
            cpu_run <= 1'b1;
            osc_enable <= 1'b1;
            restart_zero <= 1'b0;
            standby_indicator <= 1'b0;
        end else begin
            state <= next_state;
            settle_cnt <= (state == isc_pkg::ISC_SETTLE_B) ? settle_cnt + 21'd1 : 21'd0;
            cpu_run <= next_run;
            osc_enable <= next_osc;
            restart_zero <= b_done;
            standby_indicator <= next_sb;
        end
    end

    // Registered request outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_req <= 1'b0;
            irq_vector <= isc_pkg::VEC_RESET;
            irq_level <= 3'd0;
            pend_flags <= isc_pkg::PEND_RST;
            rising_pin_level <= 1'b0;
            falling_pin_level <= 1'b1;
        end else begin
            irq_req <= any_live & ~(irq_ack & irq_req) & next_run;
            irq_vector <= win_vec;
            irq_level <= win_lvl;
            pend_flags <= next_pend;
            rising_pin_level <= rising_edge_irq_pin;
            falling_pin_level <= falling_edge_irq_pin;
        end
    end

    // ==========================================
    // Checks
    property p_halt_wake;
        @(posedge core_clk) disable iff (reset)
        (state == isc_pkg::ISC_HALT && any_live && stop_n_pin) |=> cpu_run;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not released");

    property p_stopa_osc;
        @(posedge core_clk) disable iff (reset)
        (state == isc_pkg::ISC_STOPA) |-> !osc_enable;
    endproperty
    a_stopa_osc: assert property (p_stopa_osc) else $error("osc on in stop A");

    property p_stopb_enter;
        @(posedge core_clk) disable iff (reset)
        !stop_n_pin |=> !osc_enable && !cpu_run;
    endproperty
    a_stopb_enter: assert property (p_stopb_enter) else $error("stop pin ignored");

    property p_restart;
        @(posedge core_clk) disable iff (reset)
        restart_zero |-> cpu_run && $past(state) == isc_pkg::ISC_SETTLE_B;
    endproperty
    a_restart: assert property (p_restart) else $error("bad restart");

    property p_level1;
        @(posedge core_clk) disable iff (reset)
        (!lv0 && lv1) |=> irq_vector == isc_pkg::VEC_L1 && irq_level == 3'd1;
    endproperty
    a_level1: assert property (p_level1) else $error("level 1 vector wrong");

    property p_nmi_first;
        @(posedge core_clk) disable iff (reset)
        lv0 |=> irq_vector == isc_pkg::VEC_L0;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi lost priority");

    property p_nmi_edge;
        @(posedge core_clk) disable iff (reset)
        ($fell(nmi_n_pin) && !pend_clear[0]) |=> pend[isc_pkg::SRC_NMI];
    endproperty
    a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge missed");

    property p_sb_set;
        @(posedge core_clk) disable iff (reset)
        enter_stop |=> standby_indicator;
    endproperty
    a_sb_set: assert property (p_sb_set) else $error("standby flag not set");

    property p_level3;
        @(posedge core_clk) disable iff (reset)
        (!(lv0 || lv1 || lv2) && lv3) |=>
            irq_vector == isc_pkg::VEC_L3 && irq_level == 3'd3;
    endproperty
    a_level3: assert property (p_level3) else $error("level 3 vector wrong");

    property p_level4;
        @(posedge core_clk) disable iff (reset)
        (!(lv0 || lv1 || lv2 || lv3) && lv4) |=>
            irq_vector == isc_pkg::VEC_L4 && irq_level == 3'd4;
    endproperty
    a_level4: assert property (p_level4) else $error("level 4 vector wrong");

    property p_level5;
        @(posedge core_clk) disable iff (reset)
        (!(lv0 || lv1 || lv2 || lv3 || lv4) && lv5) |=>
            irq_vector == isc_pkg::VEC_L5 && irq_level == 3'd5;
    endproperty
    a_level5: assert property (p_level5) else $error("level 5 vector wrong");

    property p_settle_a;
        @(posedge core_clk) disable iff (reset)
        (state == isc_pkg::ISC_SETTLE_A && timer1_settle_done && stop_n_pin) |=> cpu_run;
    endproperty
    a_settle_a: assert property (p_settle_a) else $error("settle A not ended");

    property p_rise_edge;
        @(posedge core_clk) disable iff (reset)
        $rose(rising_edge_irq_pin) |=> pend[isc_pkg::SRC_RISE];
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

    property p_fall_edge;
        @(posedge core_clk) disable iff (reset)
        $fell(falling_edge_irq_pin) |=> pend[isc_pkg::SRC_FALL];
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling edge missed");

    property p_rise_level;
        @(posedge core_clk) disable iff (reset)
        rising_edge_irq_pin |=> rising_pin_level;
    endproperty
    a_rise_level: assert property (p_rise_level) else $error("rise level wrong");

    property p_fall_level;
        @(posedge core_clk) disable iff (reset)
        !falling_edge_irq_pin |=> !falling_pin_level;
    endproperty
    a_fall_level: assert property (p_fall_level) else $error("fall level wrong");

    property p_shared_keep;
        @(posedge core_clk) disable iff (reset)
        (pend[isc_pkg::SRC_SR] && !pend_clear[isc_pkg::SRC_SR]) |=> pend[isc_pkg::SRC_SR];
    endproperty
    a_shared_keep: assert property (p_shared_keep) else $error("shared flag lost");
endmodule

//--- sim/isc_partner.sv
// Model of the external interrupt pins and the stop pin driver
module isc_partner #(
    parameter int unsigned NMI_LOW = 4
) (
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset, high
    input wire logic nmi_fire, // Start one nonmaskable pulse
    input wire logic rise_level, // Level for rising input
    input wire logic fall_level, // Level for falling input
    input wire logic stop_hold, // Hold stop line low
    output logic nmi_n_pin, // Nonmaskable line, idles high
    output logic rising_edge_irq_pin, // Rising-edge input
    output logic falling_edge_irq_pin, // Falling-edge input
    output logic stop_n_pin // Stop control line
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned low_left;
    // ==========================================
    // Nonmaskable pulse, held low for a minimum width
    always_ff @(posedge core_clk) begin
        if (reset) begin
            low_left <= 0;
        end else if (nmi_fire) begin
            low_left <= NMI_LOW;
        end else if (low_left != 0) begin
            low_left <= low_left - 1;
        end
    end
    assign nmi_n_pin = (low_left == 0);
    // Comparator outputs and stop line, plain logic levels
    assign rising_edge_irq_pin = rise_level;
    assign falling_edge_irq_pin = fall_level;
    assign stop_n_pin = ~stop_hold;
endmodule

//--- sim/testbench.sv
// Self-checking bench for the interrupt and standby controller
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SETTLE = 16;
    localparam int HALT = 0, STOP = 1, SDONE = 2, SBCLR = 3, ACK = 4;
    logic core_clk, reset, nmi_fire, rise_level, fall_level, stop_hold;
    logic nmi_n_pin, rising_edge_irq_pin, falling_edge_irq_pin, stop_n_pin;
    logic [11:0] src, irq_mask, pend_clear, pend_flags;
    logic [4:0] ctl;
    logic irq_req, cpu_run, osc_enable, restart_zero, standby_indicator;
    logic rising_pin_level, falling_pin_level;
    logic [7:0] irq_vector;
    logic [2:0] irq_level;
    int bad_count, checked, cycles;
    int lvl_of [12] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6};
    logic [7:0] vec_of [7] = '{8'h04, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h60};
    // ==========================================
    // Instances
    isc_partner #(.NMI_LOW(4)) i_isc_partner (.core_clk(core_clk), .reset(reset),
        .nmi_fire(nmi_fire), .rise_level(rise_level), .fall_level(fall_level),
        .stop_hold(stop_hold), .nmi_n_pin(nmi_n_pin),
        .rising_edge_irq_pin(rising_edge_irq_pin),
        .falling_edge_irq_pin(falling_edge_irq_pin), .stop_n_pin(stop_n_pin));
    isc_ctrl #(.SETTLE_CYCLES(SETTLE)) i_isc_ctrl (.core_clk(core_clk), .reset(reset),
        .nmi_n_pin(nmi_n_pin), .rising_edge_irq_pin(rising_edge_irq_pin),
        .falling_edge_irq_pin(falling_edge_irq_pin), .stop_n_pin(stop_n_pin),
        .timer0_match_req(src[1]), .timer1_match_req(src[2]),
        .evcnt_match0_req(src[5]), .evcnt_match1_req(src[6]),
        .evcnt_falling_edge_req(src[7]), .adc_done_req(src[8]),
        .serial_rx_req(src[9]), .serial_tx_req(src[10]), .software_trap(src[11]),
        .halt_instruction(ctl[HALT]), .stop_instruction(ctl[STOP]),
        .timer1_settle_done(ctl[SDONE]), .irq_mask(irq_mask), .irq_ack(ctl[ACK]),
        .pend_clear(pend_clear), .sb_clear(ctl[SBCLR]), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_level(irq_level), .pend_flags(pend_flags),
        .cpu_run(cpu_run), .osc_enable(osc_enable), .restart_zero(restart_zero),
        .standby_indicator(standby_indicator), .rising_pin_level(rising_pin_level),
        .falling_pin_level(falling_pin_level));
    // ==========================================
    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            $display("Error timeout expected finish seen hang");
            finish_test();
        end
    end
    // ==========================================
    // Helper tasks
    task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic poke(input int b);
        @(posedge core_clk);
        ctl[b] <= 1'b1;
        @(posedge core_clk);
        ctl <= 5'h00;
    endtask
    task automatic fire(input int i);
        @(posedge core_clk);
        if (i == 0) nmi_fire <= 1'b1;
        else if (i == 3) rise_level <= 1'b1;
        else if (i == 4) fall_level <= 1'b0;
        else src[i] <= 1'b1;
        @(posedge core_clk);
        nmi_fire <= 1'b0;
        src <= 12'h000;
    endtask
    task automatic wait_req;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (irq_req !== 1'b1 && n < 8);
    endtask
    task automatic clear_all;
        @(posedge core_clk);
        pend_clear <= 12'hFFF;
        @(posedge core_clk);
        pend_clear <= 12'h000;
        rise_level <= 1'b0;
        fall_level <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic test_reset;
        #1;
        check("irq_req", 12'h000, {11'h000, irq_req});
        check("pend_flags", 12'h000, pend_flags);
        check("cpu_run", 12'h001, {11'h000, cpu_run});
        check("osc_enable", 12'h001, {11'h000, osc_enable});
        check("standby", 12'h000, {11'h000, standby_indicator});
        check("rise_level", 12'h000, {11'h000, rising_pin_level});
        check("fall_level", 12'h001, {11'h000, falling_pin_level});
        $display("test reset done");
    endtask
    // ==========================================
    // Scenarios
    task automatic test_sources;
        for (int i = 0; i < 12; i++) begin
            fire(i);
            wait_req();
            check("irq_req", 12'h001, {11'h000, irq_req});
            check("irq_level", 12'(lvl_of[i]), {9'h000, irq_level});
            check("irq_vector", {4'h0, vec_of[lvl_of[i]]}, {4'h0, irq_vector});
            check("pend_flags", 12'h001 << i, pend_flags);
            if (i == 3) check("rise_level", 12'h001, {11'h000, rising_pin_level});
            if (i == 4) check("fall_level", 12'h000, {11'h000, falling_pin_level});
            poke(ACK);
            #1;
            check("pend_after_ack", lvl_of[i] inside {1, 3, 4, 5} ? 12'h001 << i : 12'h000, pend_flags);
            clear_all();
        end
        $display("test sources done");
    endtask
    task automatic test_priority_mask;
        @(posedge core_clk);
        src <= 12'hA02;
        @(posedge core_clk);
        src <= 12'h000;
        wait_req();
        check("irq_vector", 12'h008, {4'h0, irq_vector});
        clear_all();
        irq_mask <= 12'h200;
        fire(9);
        repeat (4) @(posedge core_clk);
        #1;
        check("pend_flags", 12'h200, pend_flags);
        check("irq_req", 12'h000, {11'h000, irq_req});
        @(posedge core_clk);
        irq_mask <= 12'h000;
        clear_all();
        $display("test priority and mask done");
    endtask
    task automatic test_halt;
        poke(HALT);
        #1;
        check("cpu_run", 12'h000, {11'h000, cpu_run});
        check("osc_enable", 12'h001, {11'h000, osc_enable});
        @(posedge core_clk);
        irq_mask <= 12'h002;
        fire(1);
        repeat (3) @(posedge core_clk);
        #1;
        check("cpu_run", 12'h000, {11'h000, cpu_run});
        fire(2);
        repeat (3) @(posedge core_clk);
        #1;
        check("cpu_run", 12'h001, {11'h000, cpu_run});
        @(posedge core_clk);
        irq_mask <= 12'h000;
        clear_all();
        $display("test halt done");
    endtask
    task automatic test_stop_a;
        poke(STOP);
        @(posedge core_clk);
        #1;
        check("osc_enable", 12'h000, {11'h000, osc_enable});
        check("cpu_run", 12'h000, {11'h000, cpu_run});
        check("standby", 12'h001, {11'h000, standby_indicator});
        fire(1);
        repeat (3) @(posedge core_clk);
        #1;
        check("cpu_run", 12'h000, {11'h000, cpu_run});
        fire(0);
        repeat (8) @(posedge core_clk);
        #1;
        check("cpu_run", 12'h000, {11'h000, cpu_run});
        poke(SDONE);
        repeat (2) @(posedge core_clk);
        #1;
        check("cpu_run", 12'h001, {11'h000, cpu_run});
        check("standby", 12'h001, {11'h000, standby_indicator});
        poke(SBCLR);
        @(posedge core_clk);
        #1;
        check("standby", 12'h000, {11'h000, standby_indicator});
        clear_all();
        $display("test stop by instruction done");
    endtask
    task automatic test_stop_b;
        int n;
        n = 0;
        @(posedge core_clk);
        stop_hold <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("osc_enable", 12'h000, {11'h000, osc_enable});
        @(posedge core_clk);
        stop_hold <= 1'b0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (restart_zero !== 1'b1 && n < SETTLE + 8);
        check("settle_in_range", 12'h001, {11'h000, n >= SETTLE && n <= SETTLE + 4});
        @(posedge core_clk);
        #1;
        check("cpu_run", 12'h001, {11'h000, cpu_run});
        poke(HALT);
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        $display("test stop by pin done");
        test_reset();
    endtask
    // ==========================================
    // Verdict and main sequence
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {reset, nmi_fire, rise_level, stop_hold} = 4'h8;
        fall_level = 1'b1;
        {src, irq_mask, pend_clear} = 36'h0_0000_0000;
        ctl = 5'h00;
        bad_count = 0;
        checked = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        test_reset();
        test_sources();
        test_priority_mask();
        test_halt();
        test_stop_a();
        test_stop_b();
        finish_test();
    end
endmodule
